// File: ccr_cache_ctrl.sv
// Cache control and cache entry address registers with their effects.
// Assumes the move-to-control instruction gives one-cycle write strobes,
// and the cache datapaths act on the steering outputs.
`timescale 1ns/1ps

// Functional notes
// - Write-allocate bit 13 selects write allocation
// - Write-allocate ignored when data cache off/frozen
// - Reset clears all stored control bits
// - Data clear-all write invalidates whole data cache
// - Data clear-all reads as zero
// - Data clear-entry invalidates indexed long word only
// - Data clear-entry reads as zero
// - Data freeze blocks miss replacement
// - Frozen data cache still updates on write hit
// - Unfrozen read miss fills; write miss per allocate
// - Bit 8 enables data cache
// - Data disable keeps valid bits
// - Instruction clear-all invalidates whole instruction cache
// - Instruction clear-all reads as zero
// - Instruction clear-entry invalidates indexed long word
// - Instruction clear-entry reads as zero
// - Instruction freeze blocks miss replacement
// - Bit 0 enables instruction cache, keeps entries
// - Address register index bits 7-2 select entry
module ccr_cache_ctrl
    import ccr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ctrl_wr,
    input wire logic addr_wr,
    input wire logic [31:0] wr_data,
    input wire logic d_read_miss,
    input wire logic d_write_miss,
    input wire logic d_write_hit,
    input wire logic i_miss,
    output logic [31:0] ctrl_rd_ff,
    output logic [31:0] addr_rd_ff,
    output logic d_enable_ff,
    output logic i_enable_ff,
    output logic d_burst_ok_ff,
    output logic i_burst_ok_ff,
    output logic d_inval_all_ff,
    output logic i_inval_all_ff,
    output logic d_inval_one_ff,
    output logic i_inval_one_ff,
    output logic [CCR_IDX_W-1:0] inval_idx_ff,
    output logic d_fill_ff,
    output logic d_update_ff,
    output logic i_fill_ff
);

    ////////////////////////////////////////////////////////////////////////
    logic [31:0] ctrl_ff;
    logic [31:0] addr_ff;
    logic wa_eff;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_ff <= CCR_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_ff <= wr_data & CCR_CTRL_MASK;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            addr_ff <= CCR_ADDR_RESET;
        end else if (addr_wr) begin
            addr_ff <= wr_data;
        end
    end

    // clear bits never stored, read zero
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_rd_ff <= CCR_CTRL_RESET;
            addr_rd_ff <= CCR_ADDR_RESET;
        end else begin
            ctrl_rd_ff <= ctrl_wr ? (wr_data & CCR_CTRL_MASK) : ctrl_ff;
            addr_rd_ff <= addr_wr ? wr_data : addr_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data and instruction enables, burst permits
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            d_enable_ff <= 1'b0;
            i_enable_ff <= 1'b0;
            d_burst_ok_ff <= 1'b0;
            i_burst_ok_ff <= 1'b0;
        end else begin
            d_enable_ff <= ctrl_ff[CCR_DEN_POS];
            i_enable_ff <= ctrl_ff[CCR_IEN_POS];
            d_burst_ok_ff <= ctrl_ff[CCR_DBE_POS] & ctrl_ff[CCR_DEN_POS];
            i_burst_ok_ff <= ctrl_ff[CCR_IBE_POS] & ctrl_ff[CCR_IEN_POS];
        end
    end

    // data clear entry regardless of enable/freeze
    // instruction clear entry regardless of enable/freeze
    // enable writes never touch valid bits
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            d_inval_all_ff <= 1'b0;
            i_inval_all_ff <= 1'b0;
            d_inval_one_ff <= 1'b0;
            i_inval_one_ff <= 1'b0;
        end else begin
            d_inval_all_ff <= ctrl_wr & wr_data[CCR_CDA_POS];
            i_inval_all_ff <= ctrl_wr & wr_data[CCR_ICA_POS];
            d_inval_one_ff <= ctrl_wr & wr_data[CCR_CDE_POS];
            i_inval_one_ff <= ctrl_wr & wr_data[CCR_ICE_POS];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            inval_idx_ff <= '0;
        end else begin
            inval_idx_ff <= addr_ff[CCR_IDX_MSB:CCR_IDX_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // allocate only counts when enabled and unfrozen
    assign wa_eff = ctrl_ff[CCR_WA_POS] & ctrl_ff[CCR_DEN_POS] & ~ctrl_ff[CCR_DFZ_POS];

    // read miss fills, write miss by allocate
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            d_fill_ff <= 1'b0;
            d_update_ff <= 1'b0;
            i_fill_ff <= 1'b0;
        end else begin
            d_fill_ff <= ctrl_ff[CCR_DEN_POS] & ~ctrl_ff[CCR_DFZ_POS]
                & (d_read_miss | (d_write_miss & wa_eff));
            d_update_ff <= ctrl_ff[CCR_DEN_POS] & d_write_hit;
            i_fill_ff <= ctrl_ff[CCR_IEN_POS] & ~ctrl_ff[CCR_IFZ_POS] & i_miss;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clear-all pulse follows write
    a_dclr_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
        ctrl_wr && wr_data[CCR_CDA_POS] |=> d_inval_all_ff) else $error("no data clear");
    a_iclr_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
        ctrl_wr && wr_data[CCR_ICA_POS] |=> i_inval_all_ff) else $error("no instr clear");
    a_clr_readzero: assert property (@(posedge clk_sys) disable iff (!rstn)
        ctrl_rd_ff[CCR_CDA_POS] == 1'b0 && ctrl_rd_ff[CCR_CDE_POS] == 1'b0
        && ctrl_rd_ff[CCR_ICA_POS] == 1'b0 && ctrl_rd_ff[CCR_ICE_POS] == 1'b0)
        else $error("clear bit read one");
    a_undef_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        (ctrl_rd_ff & ~CCR_CTRL_MASK) == 32'h0000_0000) else $error("undefined bit set");
    a_dfreeze_nofill: assert property (@(posedge clk_sys) disable iff (!rstn)
        ctrl_ff[CCR_DFZ_POS] |=> !d_fill_ff) else $error("frozen data fill");
    a_dhit_update: assert property (@(posedge clk_sys) disable iff (!rstn)
        ctrl_ff[CCR_DEN_POS] && d_write_hit |=> d_update_ff) else $error("hit not updated");
    a_ifreeze_nofill: assert property (@(posedge clk_sys) disable iff (!rstn)
        ctrl_ff[CCR_IFZ_POS] |=> !i_fill_ff) else $error("frozen instr fill");
    a_wmiss_alloc: assert property (@(posedge clk_sys) disable iff (!rstn)
        d_write_miss && !d_read_miss |=> d_fill_ff == $past(wa_eff)) else $error("alloc wrong");
    a_dentry_idx: assert property (@(posedge clk_sys) disable iff (!rstn)
        ctrl_wr && wr_data[CCR_CDE_POS] |=> d_inval_one_ff
        && inval_idx_ff == $past(addr_ff[CCR_IDX_MSB:CCR_IDX_LSB])) else $error("entry bad");
    a_ctrl_readback: assert property (@(posedge clk_sys) disable iff (!rstn)
        ctrl_wr |=> ctrl_rd_ff == ($past(wr_data) & CCR_CTRL_MASK)) else $error("readback bad");

    ////////////////////////////////////////////////////////////////////////
    // Write sequences; effects on enables land two edges later
    sequence s_den_set;
        ctrl_wr && wr_data[CCR_DEN_POS];
    endsequence

    sequence s_den_clr;
        ctrl_wr && !wr_data[CCR_DEN_POS];
    endsequence

    sequence s_ien_set;
        ctrl_wr && wr_data[CCR_IEN_POS];
    endsequence

    sequence s_ien_clr;
        ctrl_wr && !wr_data[CCR_IEN_POS];
    endsequence

    sequence s_dbe_set;
        ctrl_wr && wr_data[CCR_DBE_POS] && wr_data[CCR_DEN_POS];
    endsequence

    sequence s_ibe_set;
        ctrl_wr && wr_data[CCR_IBE_POS] && wr_data[CCR_IEN_POS];
    endsequence

    a_den_on: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_den_set |=> ##1 d_enable_ff) else $error("data enable not set");

    a_den_off: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_den_clr |=> ##1 !d_enable_ff) else $error("data enable not clear");

    a_ien_on: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_ien_set |=> ##1 i_enable_ff) else $error("instr enable not set");

    a_ien_off: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_ien_clr |=> ##1 !i_enable_ff) else $error("instr enable not clear");

    a_dburst_on: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_dbe_set |=> ##1 d_burst_ok_ff) else $error("data burst not set");

    a_dburst_off: assert property (@(posedge clk_sys) disable iff (!rstn)
        ctrl_wr && !wr_data[CCR_DBE_POS] |=> ##1 !d_burst_ok_ff)
        else $error("data burst not clear");

    a_iburst_on: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_ibe_set |=> ##1 i_burst_ok_ff) else $error("instr burst not set");

    a_iburst_off: assert property (@(posedge clk_sys) disable iff (!rstn)
        ctrl_wr && !wr_data[CCR_IBE_POS] |=> ##1 !i_burst_ok_ff)
        else $error("instr burst not clear");

    // data valid bits only cleared by command
    a_dclr_only: assert property (@(posedge clk_sys) disable iff (!rstn)
        d_inval_all_ff |-> $past(ctrl_wr) && $past(wr_data[CCR_CDA_POS]))
        else $error("stray data clear");

    // instruction valid bits only cleared by command
    a_iclr_only: assert property (@(posedge clk_sys) disable iff (!rstn)
        i_inval_all_ff |-> $past(ctrl_wr) && $past(wr_data[CCR_ICA_POS]))
        else $error("stray instr clear");

    // data entry clear only by command
    a_dent_only: assert property (@(posedge clk_sys) disable iff (!rstn)
        d_inval_one_ff |-> $past(ctrl_wr) && $past(wr_data[CCR_CDE_POS]))
        else $error("stray data entry clear");

    // instruction entry clear only by command
    a_ient_only: assert property (@(posedge clk_sys) disable iff (!rstn)
        i_inval_one_ff |-> $past(ctrl_wr) && $past(wr_data[CCR_ICE_POS]))
        else $error("stray instr entry clear");

    a_ientry_idx: assert property (@(posedge clk_sys) disable iff (!rstn)
        ctrl_wr && wr_data[CCR_ICE_POS] |=> i_inval_one_ff
        && inval_idx_ff == $past(addr_ff[CCR_IDX_MSB:CCR_IDX_LSB]))
        else $error("instr entry bad");

    a_dfill_off: assert property (@(posedge clk_sys) disable iff (!rstn)
        !ctrl_ff[CCR_DEN_POS] |=> !d_fill_ff) else $error("disabled data fill");

    a_ifill_off: assert property (@(posedge clk_sys) disable iff (!rstn)
        !ctrl_ff[CCR_IEN_POS] |=> !i_fill_ff) else $error("disabled instr fill");

    a_dread_fill: assert property (@(posedge clk_sys) disable iff (!rstn)
        ctrl_ff[CCR_DEN_POS] && !ctrl_ff[CCR_DFZ_POS] && d_read_miss |=> d_fill_ff)
        else $error("read miss not filled");

    a_imiss_fill: assert property (@(posedge clk_sys) disable iff (!rstn)
        ctrl_ff[CCR_IEN_POS] && !ctrl_ff[CCR_IFZ_POS] && i_miss |=> i_fill_ff)
        else $error("instr miss not filled");

    // allocate ignored when off or frozen
    a_wa_ignored: assert property (@(posedge clk_sys) disable iff (!rstn)
        !ctrl_ff[CCR_DEN_POS] || ctrl_ff[CCR_DFZ_POS] |-> !wa_eff)
        else $error("allocate not ignored");

    a_dfill_cause: assert property (@(posedge clk_sys) disable iff (!rstn)
        !d_read_miss && !d_write_miss |=> !d_fill_ff) else $error("fill without miss");

    a_dupd_cause: assert property (@(posedge clk_sys) disable iff (!rstn)
        !d_write_hit |=> !d_update_ff) else $error("update without hit");

    a_addr_readback: assert property (@(posedge clk_sys) disable iff (!rstn)
        addr_wr |=> addr_rd_ff == $past(wr_data)) else $error("address readback bad");

    a_ctrl_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        !ctrl_wr |=> $stable(ctrl_rd_ff)) else $error("readback drifted");

endmodule // ccr_cache_ctrl

// File: ccr_pkg.sv
// Package for the cache control register block.
// Assumes a single processor clock domain and supervisor-only register writes.
package ccr_pkg;
    localparam int CCR_WA_POS = 13;
    localparam int CCR_DBE_POS = 12;
    localparam int CCR_CDA_POS = 11;
    localparam int CCR_CDE_POS = 10;
    localparam int CCR_DFZ_POS = 9;
    localparam int CCR_DEN_POS = 8;
    localparam int CCR_IBE_POS = 4;
    localparam int CCR_ICA_POS = 3;
    localparam int CCR_ICE_POS = 2;
    localparam int CCR_IFZ_POS = 1;
    localparam int CCR_IEN_POS = 0;
    localparam int CCR_IDX_LSB = 2;
    localparam int CCR_IDX_MSB = 7;
    localparam int CCR_IDX_W = CCR_IDX_MSB - CCR_IDX_LSB + 1;
    localparam logic [31:0] CCR_CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CCR_ADDR_RESET = 32'h0000_0000;
    // Bits that store; clear bits and undefined bits never store
    localparam logic [31:0] CCR_CTRL_MASK = 32'h0000_3313;
endpackage

// File: tb_top.sv
// Self-checking bench for the cache control and cache entry address registers.
// Assumes the block takes one-cycle write strobes and level lookup events.
`timescale 1ns/1ps
module tb_top;
    import ccr_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic ctrl_wr = 1'b0;
    logic addr_wr = 1'b0;
    logic [31:0] wr_data = 32'h0000_0000;
    logic [3:0] evs = 4'h0;
    logic [31:0] ctrl_rd, addr_rd;
    logic [CCR_IDX_W-1:0] idx;
    logic d_en, i_en, d_bo, i_bo, d_ia, i_ia, d_io, i_io, d_fill, d_upd, i_fill;
    int err_count = 0;
    int checks_done = 0;
    // Per config: expected {d_fill,d_update,i_fill} for read miss, write miss, hit, i miss
    logic [31:0] cfg_tab [4] = '{32'h0000_0101, 32'h0000_2101, 32'h0000_2303, 32'h0000_2000};
    logic [11:0] exp_tab [4] = '{12'h811, 12'h911, 12'h010, 12'h000};
    ccr_cache_ctrl dut (.clk_sys(clk_sys), .rstn(rstn), .ctrl_wr(ctrl_wr), .addr_wr(addr_wr),
        .wr_data(wr_data), .d_read_miss(evs[3]), .d_write_miss(evs[2]), .d_write_hit(evs[1]),
        .i_miss(evs[0]), .ctrl_rd_ff(ctrl_rd), .addr_rd_ff(addr_rd), .d_enable_ff(d_en),
        .i_enable_ff(i_en), .d_burst_ok_ff(d_bo), .i_burst_ok_ff(i_bo), .d_inval_all_ff(d_ia),
        .i_inval_all_ff(i_ia), .d_inval_one_ff(d_io), .i_inval_one_ff(i_io),
        .inval_idx_ff(idx), .d_fill_ff(d_fill), .d_update_ff(d_upd), .i_fill_ff(i_fill));
    always #25 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks_done++;
        if (got !== ex) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // Sel high writes cache_control, low writes cache_entry_address
    task automatic wr_reg(input logic sel, input logic [31:0] v);
        @(posedge clk_sys);
        ctrl_wr <= sel;
        addr_wr <= !sel;
        wr_data <= v;
        @(posedge clk_sys);
        ctrl_wr <= 1'b0;
        addr_wr <= 1'b0;
        #1;
    endtask
    task automatic ev(input logic [3:0] e);
        @(posedge clk_sys);
        evs <= e;
        @(posedge clk_sys);
        evs <= 4'h0;
        #1;
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Whole run is about 70 cycles; the 2000-cycle limit is ample margin
    initial begin
        #100000;
        err_count++;
        close_out();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        #1;
        chk("ctrl_rd", 32'h0, ctrl_rd); // Reset value
        chk("outputs", 32'h0, {addr_rd[0], idx, d_en, i_en, d_bo, i_bo, d_ia, i_ia, d_io,
            i_io, d_fill, d_upd, i_fill}); // Reset outputs
        $display("test reset done");
        wr_reg(1'b1, 32'hFFFF_FFFF);
        chk("pulses", 32'hF, {d_ia, i_ia, d_io, i_io}); // Clear pulses
        chk("ctrl_rd", 32'h0000_3313, ctrl_rd); // Masked readback
        repeat (2) @(posedge clk_sys);
        #1;
        chk("pulses", 32'h0, {d_ia, i_ia, d_io, i_io}); // Single cycle pulse
        chk("enables", 32'hF, {d_en, i_en, d_bo, i_bo}); // Enable and burst
        $display("test control write done");
        wr_reg(1'b0, 32'hFFFF_FFA8);
        chk("addr_rd", 32'hFFFF_FFA8, addr_rd); // All 32 bits kept
        // Clear entry written while caches are still on; the same write turns them off
        wr_reg(1'b1, 32'h0000_0404);
        chk("pulses", 32'h3, {d_ia, i_ia, d_io, i_io}); // Entry only
        chk("idx", 32'h2A, idx); // Index from bits 7-2
        chk("ctrl_rd", 32'h0, ctrl_rd); // Entry bits read zero
        repeat (2) @(posedge clk_sys);
        #1;
        chk("enables", 32'h0, {d_en, i_en, d_bo, i_bo}); // Disabled
        $display("test clear entry done");
        for (int c = 0; c < 4; c++) begin
            wr_reg(1'b1, cfg_tab[c]);
            repeat (2) @(posedge clk_sys);
            for (int k = 0; k < 4; k++) begin
                ev(4'h8 >> k);
                chk("fill", exp_tab[c][11-3*k -: 3], {d_fill, d_upd, i_fill});
            end
        end
        $display("test fill table done");
        wr_reg(1'b1, 32'h0000_3313);
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b0;
        #1;
        chk("ctrl_rd", 32'h0, ctrl_rd); // Mid-run reset
        chk("enables", 32'h0, {d_en, i_en, d_bo, i_bo}); // Mid-run reset
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk("ctrl_rd", 32'h0, ctrl_rd); // Stays clear after release
        $display("test second reset done");
        close_out();
    end
endmodule // tb_top
